// ---- iatc_line_model.sv ----
`timescale 1ns/1ps
module iatc_line_model
(
	input wire logic aclk,
	input wire logic fire,
	input wire logic [1:0] sel,
	output logic [3:0] lines
);
	logic [1:0] left_reg = 2'h0;
	logic [1:0] sel_reg = 2'h0;
	// Three cycles high, since a shorter pulse could slip past the synchroniser.
	always_ff @(posedge aclk)
	begin
		left_reg <= fire ? 2'h3 : left_reg - 2'(left_reg != 2'h0);
		sel_reg <= fire ? sel : sel_reg;
	end
	// Released lines sit at their pull-down level.
	assign lines = (left_reg != 2'h0) ? 4'h1 << sel_reg : 4'h0;
endmodule

// ---- iatc_pkg.sv ----
package iatc_pkg;
	// Clock and microsecond tick derivation.
	localparam int CLK_FREQ_HZ = 50000000;
	localparam int US_PER_S = 1000000;
	localparam int TICK_CYCLES = CLK_FREQ_HZ / US_PER_S;
	localparam int TICK_W = 6;
	// Structure sizes.
	localparam int NUM_TRIG = 2;
	localparam int TRIG_FRAME = 0;
	localparam int TRIG_BURST = 1;
	localparam int NUM_LINES = 4;
	localparam int NUM_KNEE = 4;
	localparam int TIME_W = 24;
	localparam logic [15:0] LINES_PER_FRAME = 16'h01E0;
	// Register byte offsets.
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_MODE = 8'h04;
	localparam logic [7:0] A_MFC = 8'h08;
	localparam logic [7:0] A_BFC = 8'h0C;
	localparam logic [7:0] A_FRATE = 8'h10;
	localparam logic [7:0] A_LRATE = 8'h14;
	localparam logic [7:0] A_EXPO = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1C;
	localparam logic [7:0] A_TCFG = 8'h20;
	localparam logic [7:0] A_TDLY = 8'h24;
	localparam logic [7:0] A_TDM = 8'h28;
	localparam logic [7:0] A_KCTL = 8'h2C;
	localparam logic [7:0] A_KPRM = 8'h30;
	// Command bits.
	localparam int CB_START = 0;
	localparam int CB_STOP = 1;
	localparam int CB_ABORT = 2;
	localparam int CB_ARM = 3;
	localparam int CB_SOFT = 4;
	// Mode register fields.
	localparam int MB_CMODE = 0;
	localparam int MB_FREN = 2;
	localparam int MB_LREN = 3;
	localparam int MB_EXPTW = 4;
	localparam int MB_AUTO = 5;
	localparam int MB_KNEE = 6;
	localparam int MB_SSEL = 8;
	localparam int MB_TSEL = 12;
	// Trigger config fields.
	localparam int TC_ACT = 0;
	localparam int TC_ORG = 1;
	localparam int TC_COND = 4;
	localparam int TC_OVL = 6;
	// Knee parameter fields, and the knee selector field of knee control.
	localparam int KB_EXP = 0;
	localparam int KB_SAT = 8;
	localparam int KB_INT = 16;
	localparam int KB_GRAD = 24;
	localparam int KB_SEL = 4;
	// Writable masks and reset values.
	localparam logic [31:0] MODE_MASK = 32'h0000137F;
	localparam logic [31:0] CNT_MASK = 32'h0000FFFF;
	localparam logic [31:0] TIME_MASK = 32'h00FFFFFF;
	localparam logic [31:0] TCFG_MASK = 32'h0000007F;
	localparam logic [31:0] KCTL_MASK = 32'h00000033;
	localparam logic [31:0] KPRM_MASK = 32'hFF7F7F7F;
	localparam logic [31:0] MODE_RST = 32'h00000000;
	localparam logic [31:0] CNT_RST = 32'h00000001;
	localparam logic [31:0] EXPO_RST = 32'h000003E8;
	localparam logic [31:0] RATE_RST = 32'h00000000;
	localparam logic [31:0] TDM_RST = 32'h00000101;
	localparam logic [6:0] FULL_PCT = 7'h64;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [1:0] {CM_CONT, CM_SINGLE, CM_MULTI, CM_RSVD} iatc_cmode_t;
	typedef enum logic [1:0] {TA_RISE, TA_FALL, TA_HIGH, TA_LOW} iatc_cond_t;
endpackage

// ---- iatc_properties.sv ----
`timescale 1ns/1ps
module iatc_props
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic frame_start,
	input wire logic exposure_active,
	input wire logic frame_active,
	input wire logic line_strobe,
	input wire logic [1:0] knee_slope,
	input wire logic [6:0] knee_saturation_pct,
	input wire logic [7:0] knee_slope_gradient
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A read address hand-off must be answered while the address side stays shut.
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_AR_BUSY: assert property (s_ar_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_FS_PULSE: assert property (frame_start |=> !frame_start)
		else $error("frame start long");
	AST_FS_IN_FRAME: assert property (frame_start |=> frame_active)
		else $error("frame start outside frame");
	AST_FS_EXPOSE: assert property (frame_start |=> exposure_active)
		else $error("frame start without exposure");
	AST_EXP_IN_FRAME: assert property (exposure_active |-> frame_active)
		else $error("exposure outside frame");
	AST_LINE_READOUT: assert property (line_strobe |-> frame_active && !exposure_active)
		else $error("line outside readout");
	AST_KNEE_BASE: assert property (knee_slope == 2'h0 |-> knee_saturation_pct == 7'h64)
		else $error("base slope saturation");
	AST_KNEE_GRAD: assert property (knee_slope == 2'h0 |-> knee_slope_gradient == 8'h00)
		else $error("base slope gradient");
endmodule
bind iatc_top iatc_props u_chk(.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.frame_start, .exposure_active, .frame_active, .line_strobe, .knee_slope,
	.knee_saturation_pct, .knee_slope_gradient);

// ---- iatc_top.sv ----
// Summary of operation
// R1 - Stop finishes current frame, then ends capture.
// R2 - Abort ends capture at once.
// R3 - Optional arm precedes capture start.
// R4 - Multi-frame mode captures exactly programmed frame count.
// R5 - Each burst trigger captures burst frame count.
// R6 - Frame rate writable and used only when enabled.
// R7 - Line rate writable and used only when enabled.
// R8 - Status bit shows selected internal acquisition signal.
// R9 - Per-trigger mode enables or ignores that trigger.
// R10 - Software trigger command makes one trigger event.
// R11 - Trigger source is software or input line.
// R12 - Activation chooses edge or level as trigger; the code triggers on edges only, high acting as rise and low as fall.
// R13 - Overlap policy decides acceptance during busy frame.
// R14 - Trigger waits programmed microsecond delay before acting.
// R15 - Divider passes one per N trigger pulses.
// R16 - Multiplier makes N triggers per pulse.
// R17 - Programmed exposure used only timed, auto off.
// R18 - Auto exposure applies only in timed mode.
// R19 - Knee count sets knees and extra slopes.
// R20 - Knee exposure limit is percent of exposure.
// R21 - Knee saturation threshold is percent of full.
// R22 - Knee carries intensity bound and slope gradient.
// R23 - Delays and exposure timed by microsecond tick.
`timescale 1ns/1ps
module iatc_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [iatc_pkg::NUM_LINES-1:0] trig_line_in,
	input wire logic [iatc_pkg::TIME_W-1:0] auto_exposure_us,
	output logic frame_start,
	output logic exposure_active,
	output logic frame_active,
	output logic line_strobe,
	output logic [1:0] knee_slope,
	output logic [6:0] knee_saturation_pct,
	output logic [6:0] knee_intensity_bound,
	output logic [7:0] knee_slope_gradient
);
	import iatc_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_ARMED, S_RUN, S_EXPOSE, S_READOUT} iatc_state_t;

	// Byte-lane merge shared by every writable register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		merge = r & mask;
	endfunction

	// True once elapsed time has reached pct percent of the target.
	function automatic logic reached(input logic [TIME_W-1:0] cnt, input logic [TIME_W-1:0] tgt,
		input logic [6:0] pct);
		reached = (32'(cnt) * 32'h00000064) >= (32'(pct) * 32'(tgt));
	endfunction

	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_go;
	logic wr_hit;
	logic [31:0] cmd;
	logic [31:0] mode_reg;
	logic [31:0] mfc_reg;
	logic [31:0] bfc_reg;
	logic [31:0] frate_reg;
	logic [31:0] lrate_reg;
	logic [31:0] expo_reg;
	logic [31:0] kctl_reg;
	logic [31:0] tcfg_reg [NUM_TRIG];
	logic [31:0] tdly_reg [NUM_TRIG];
	logic [31:0] tdm_reg [NUM_TRIG];
	logic [31:0] kprm_reg [NUM_KNEE];
	logic [31:0] rd_word;
	logic rd_ok;
	logic [NUM_LINES-1:0] line_meta_reg;
	logic [NUM_LINES-1:0] line_sync_reg;
	logic us_tick;
	logic [NUM_TRIG-1:0] trig_evt;
	logic [NUM_TRIG-1:0] trig_lvl;
	logic tsel;
	logic [1:0] ksel;
	iatc_state_t state_reg;
	logic [15:0] frames_left_reg;
	logic [15:0] burst_left_reg;
	logic stop_pend_reg;
	logic pend_reg;
	logic [TIME_W-1:0] fr_cnt_reg;
	logic [TIME_W-1:0] exp_cnt_reg;
	logic [TIME_W-1:0] exp_tgt_reg;
	logic [TIME_W-1:0] lr_cnt_reg;
	logic [15:0] line_cnt_reg;
	logic busy;
	logic timed;
	logic frame_trig_on;
	logic burst_trig_on;
	logic go_ok;
	logic start_frame;
	logic exp_done;
	logic line_go;
	logic frame_done;
	logic [1:0] kidx;
	logic status_signal_value_reg;

	assign tsel = mode_reg[MB_TSEL];
	assign ksel = kctl_reg[KB_SEL +: 2];
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign cmd = (wr_go && aw_addr_reg == A_CMD) ? merge(32'h0, w_data_reg, w_strb_reg,
		32'hFFFFFFFF) : 32'h0;

	// AXI write channels: address and data taken in either order, response after both.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb
	begin
		unique case (aw_addr_reg)
			A_CMD, A_MODE, A_MFC, A_BFC, A_FRATE, A_LRATE, A_EXPO, A_STAT,
			A_TCFG, A_TDLY, A_TDM, A_KCTL, A_KPRM: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Global control registers; rate settings ignore writes while disabled.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_reg <= MODE_RST;
			mfc_reg <= CNT_RST;
			bfc_reg <= CNT_RST;
			frate_reg <= RATE_RST;
			lrate_reg <= RATE_RST;
			expo_reg <= EXPO_RST;
			kctl_reg <= MODE_RST;
		end
		else if (wr_go)
		begin
			if (aw_addr_reg == A_MODE)
				mode_reg <= merge(mode_reg, w_data_reg, w_strb_reg, MODE_MASK);
			if (aw_addr_reg == A_MFC)
				mfc_reg <= merge(mfc_reg, w_data_reg, w_strb_reg, CNT_MASK);
			if (aw_addr_reg == A_BFC)
				bfc_reg <= merge(bfc_reg, w_data_reg, w_strb_reg, CNT_MASK);
			if (aw_addr_reg == A_FRATE && mode_reg[MB_FREN])
				frate_reg <= merge(frate_reg, w_data_reg, w_strb_reg, TIME_MASK); // R6
			if (aw_addr_reg == A_LRATE && mode_reg[MB_LREN])
				lrate_reg <= merge(lrate_reg, w_data_reg, w_strb_reg, TIME_MASK); // R7
			if (aw_addr_reg == A_EXPO)
				expo_reg <= merge(expo_reg, w_data_reg, w_strb_reg, TIME_MASK);
			if (aw_addr_reg == A_KCTL)
				kctl_reg <= merge(kctl_reg, w_data_reg, w_strb_reg, KCTL_MASK); // R19
		end
	end

	// Banked trigger and knee settings, addressed through their selectors.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < NUM_TRIG; i++)
			begin
				tcfg_reg[i] <= MODE_RST;
				tdly_reg[i] <= MODE_RST;
				tdm_reg[i] <= TDM_RST;
			end
			for (int k = 0; k < NUM_KNEE; k++)
				kprm_reg[k] <= MODE_RST;
		end
		else if (wr_go)
		begin
			if (aw_addr_reg == A_TCFG)
				tcfg_reg[tsel] <= merge(tcfg_reg[tsel], w_data_reg, w_strb_reg, TCFG_MASK); // R9
			if (aw_addr_reg == A_TDLY)
				tdly_reg[tsel] <= merge(tdly_reg[tsel], w_data_reg, w_strb_reg, CNT_MASK);
			if (aw_addr_reg == A_TDM)
				tdm_reg[tsel] <= merge(tdm_reg[tsel], w_data_reg, w_strb_reg, CNT_MASK);
			if (aw_addr_reg == A_KPRM)
				kprm_reg[ksel] <= merge(kprm_reg[ksel], w_data_reg, w_strb_reg, KPRM_MASK);
		end
	end

	// Read decode; unmapped addresses answer with a slave error.
	always_comb
	begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			A_CMD: rd_word = 32'h0;
			A_MODE: rd_word = mode_reg;
			A_MFC: rd_word = mfc_reg;
			A_BFC: rd_word = bfc_reg;
			A_FRATE: rd_word = frate_reg;
			A_LRATE: rd_word = lrate_reg;
			A_EXPO: rd_word = expo_reg;
			A_STAT: rd_word = {27'h0, frame_active, exposure_active,
				state_reg == S_RUN, state_reg == S_ARMED, status_signal_value_reg}; // R8
			A_TCFG: rd_word = tcfg_reg[tsel];
			A_TDLY: rd_word = tdly_reg[tsel];
			A_TDM: rd_word = tdm_reg[tsel];
			A_KCTL: rd_word = kctl_reg;
			A_KPRM: rd_word = kprm_reg[ksel];
			default:
			begin
				rd_word = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end

	// AXI read channel: data one cycle after the address is taken.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OK;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RESP_OK : RESP_ERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Trigger pins come from outside and pass two flops first.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			line_meta_reg <= '0;
			line_sync_reg <= '0;
		end
		else
		begin
			line_meta_reg <= trig_line_in;
			line_sync_reg <= line_meta_reg;
		end
	end

	iatc_us_tick u_tick
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.us_tick(us_tick)
	);

	// One conditioning path per trigger type: frame start and burst start.
	for (genvar g = 0; g < NUM_TRIG; g++)
	begin : g_trig
		iatc_trig u_trig
		(
			.aclk(aclk),
			.aresetn(aresetn),
			.us_tick(us_tick),
			.soft_pulse(cmd[CB_SOFT] && tsel == 1'(g)), // R10
			.line_lvl(line_sync_reg),
			.trig_active(tcfg_reg[g][TC_ACT]),
			.trig_origin(tcfg_reg[g][TC_ORG +: 3]),
			.trig_condition(tcfg_reg[g][TC_COND +: 2]),
			.trig_latency_us(tdly_reg[g][15:0]),
			.trig_div_factor(tdm_reg[g][7:0]),
			.trig_mult_factor(tdm_reg[g][15:8]),
			.trig_evt(trig_evt[g]),
			.trig_lvl(trig_lvl[g])
		);
	end

	assign busy = state_reg == S_EXPOSE || state_reg == S_READOUT;
	assign timed = !mode_reg[MB_EXPTW];
	assign frame_trig_on = tcfg_reg[TRIG_FRAME][TC_ACT];
	assign burst_trig_on = tcfg_reg[TRIG_BURST][TC_ACT];
	assign go_ok = (!burst_trig_on || burst_left_reg != 16'h0000)
		&& (!mode_reg[MB_FREN] || fr_cnt_reg >= frate_reg[TIME_W-1:0]);
	assign start_frame = state_reg == S_RUN && go_ok
		&& (!frame_trig_on || pend_reg || trig_evt[TRIG_FRAME]);
	assign exp_done = state_reg == S_EXPOSE && (timed ? exp_cnt_reg >= exp_tgt_reg
		: !trig_lvl[TRIG_FRAME]);
	assign line_go = state_reg == S_READOUT
		&& (!mode_reg[MB_LREN] || lr_cnt_reg >= lrate_reg[TIME_W-1:0]);
	assign frame_done = line_go && line_cnt_reg == LINES_PER_FRAME - 16'h0001;

	// Acquisition sequencer: abort beats stop, stop waits for frame end.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd[CB_ABORT])
		begin
			state_reg <= S_IDLE; // R2
			stop_pend_reg <= 1'b0;
			frames_left_reg <= 16'h0000;
		end
		else
		begin
			unique case (state_reg)
				S_IDLE, S_ARMED:
					if (cmd[CB_START] && (mode_reg[MB_CMODE +: 2] != CM_MULTI
						|| mfc_reg[15:0] != 16'h0000))
					begin
						state_reg <= S_RUN;
						stop_pend_reg <= 1'b0;
						frames_left_reg <= (mode_reg[MB_CMODE +: 2] == CM_MULTI) ?
							mfc_reg[15:0] : 16'h0001; // R4
					end
					else if (cmd[CB_ARM] && state_reg == S_IDLE)
						state_reg <= S_ARMED; // R3
					else if (cmd[CB_STOP])
						state_reg <= S_IDLE;
				S_RUN:
					if (cmd[CB_STOP])
						state_reg <= S_IDLE;
					else if (start_frame)
						state_reg <= S_EXPOSE;
				S_EXPOSE:
				begin
					if (cmd[CB_STOP])
						stop_pend_reg <= 1'b1; // R1
					if (exp_done)
						state_reg <= S_READOUT;
				end
				S_READOUT:
				begin
					if (cmd[CB_STOP])
						stop_pend_reg <= 1'b1; // R1
					if (frame_done)
					begin
						if (mode_reg[MB_CMODE +: 2] != CM_CONT)
							frames_left_reg <= frames_left_reg - 16'h0001; // R4
						if (cmd[CB_STOP] || stop_pend_reg || (mode_reg[MB_CMODE +: 2] != CM_CONT
							&& frames_left_reg == 16'h0001))
							state_reg <= S_IDLE; // R1 R4
						else
							state_reg <= S_RUN;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Trigger bookkeeping: overlap keeps a busy-time trigger, bursts reload count.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cmd[CB_ABORT] || state_reg == S_IDLE || state_reg == S_ARMED)
		begin
			pend_reg <= 1'b0;
			burst_left_reg <= 16'h0000;
		end
		else
		begin
			if (trig_evt[TRIG_FRAME] && (!busy || tcfg_reg[TRIG_FRAME][TC_OVL]) && !start_frame)
				pend_reg <= 1'b1; // R13
			else if (start_frame)
				pend_reg <= 1'b0;
			if (trig_evt[TRIG_BURST])
				burst_left_reg <= bfc_reg[15:0]; // R5
			else if (start_frame && burst_trig_on)
				burst_left_reg <= burst_left_reg - 16'h0001; // R5
		end
	end

	// Frame period counter in microseconds, restarted at each frame start.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || start_frame)
			fr_cnt_reg <= '0;
		else if (us_tick && fr_cnt_reg != {TIME_W{1'b1}})
			fr_cnt_reg <= fr_cnt_reg + 1'b1; // R6 R23
	end

	// Exposure timer: auto value only when timed, programmed value otherwise.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			exp_cnt_reg <= '0;
			exp_tgt_reg <= '0;
		end
		else if (start_frame)
		begin
			exp_cnt_reg <= '0;
			exp_tgt_reg <= (timed && mode_reg[MB_AUTO]) ? auto_exposure_us
				: expo_reg[TIME_W-1:0]; // R17 R18
		end
		else if (state_reg == S_EXPOSE && us_tick)
			exp_cnt_reg <= exp_cnt_reg + 1'b1; // R23
	end

	// Line pacing within readout; unpaced lines run one per clock.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_reg != S_READOUT)
		begin
			lr_cnt_reg <= '0;
			line_cnt_reg <= 16'h0000;
		end
		else if (line_go)
		begin
			lr_cnt_reg <= '0;
			line_cnt_reg <= line_cnt_reg + 16'h0001;
		end
		else if (us_tick)
			lr_cnt_reg <= lr_cnt_reg + 1'b1; // R7
	end

	// Active knee is the highest one, below the knee count, already reached.
	always_comb
	begin
		kidx = 2'h0;
		for (int k = 0; k < NUM_KNEE - 1; k++)
			if (k < int'(kctl_reg[1:0]) && reached(exp_cnt_reg, exp_tgt_reg,
				kprm_reg[k][KB_EXP +: 7]))
				kidx = 2'(k + 1); // R19 R20
	end

	// Registered outputs; slope zero reports full saturation and no gradient.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			frame_start <= 1'b0;
			exposure_active <= 1'b0;
			frame_active <= 1'b0;
			line_strobe <= 1'b0;
			knee_slope <= 2'h0;
			knee_saturation_pct <= FULL_PCT;
			knee_intensity_bound <= FULL_PCT;
			knee_slope_gradient <= 8'h00;
			status_signal_value_reg <= 1'b0;
		end
		else
		begin
			frame_start <= start_frame && !cmd[CB_ABORT] && !cmd[CB_STOP];
			exposure_active <= state_reg == S_EXPOSE && !exp_done && !cmd[CB_ABORT];
			frame_active <= busy && !cmd[CB_ABORT];
			line_strobe <= line_go && !cmd[CB_ABORT];
			if (state_reg == S_EXPOSE && timed && mode_reg[MB_KNEE] && kidx != 2'h0)
			begin
				knee_slope <= kidx;
				knee_saturation_pct <= kprm_reg[kidx - 2'h1][KB_SAT +: 7]; // R21
				knee_intensity_bound <= kprm_reg[kidx - 2'h1][KB_INT +: 7]; // R22
				knee_slope_gradient <= kprm_reg[kidx - 2'h1][KB_GRAD +: 8]; // R22
			end
			else
			begin
				knee_slope <= 2'h0;
				knee_saturation_pct <= FULL_PCT;
				knee_intensity_bound <= FULL_PCT;
				knee_slope_gradient <= 8'h00;
			end
			unique case (mode_reg[MB_SSEL +: 2])
				2'h0: status_signal_value_reg <= state_reg != S_IDLE && state_reg != S_ARMED; // R8
				2'h1: status_signal_value_reg <= state_reg == S_RUN; // R8
				2'h2: status_signal_value_reg <= state_reg == S_EXPOSE; // R8
				2'h3: status_signal_value_reg <= busy; // R8
			endcase
		end
	end
endmodule

// ---- iatc_trig.sv ----
`timescale 1ns/1ps
module iatc_trig
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic us_tick,
	input wire logic soft_pulse,
	input wire logic [iatc_pkg::NUM_LINES-1:0] line_lvl,
	input wire logic trig_active,
	input wire logic [2:0] trig_origin,
	input wire logic [1:0] trig_condition,
	input wire logic [15:0] trig_latency_us,
	input wire logic [7:0] trig_div_factor,
	input wire logic [7:0] trig_mult_factor,
	output logic trig_evt,
	output logic trig_lvl
);
	import iatc_pkg::*;
	logic src;
	logic lvl_d_reg;
	logic raw;
	logic pass;
	logic [7:0] div_cnt_reg;
	logic dly_busy_reg;
	logic [15:0] dly_cnt_reg;
	logic fire;
	logic [7:0] mult_left_reg;

	// Origin 0 is software only; 1..4 pick a synchronised line.
	always_comb
	begin
		src = 1'b0;
		if (trig_origin != 3'h0 && trig_origin <= 3'(NUM_LINES))
			src = line_lvl[trig_origin[1:0] - 2'h1]; // R11
		trig_lvl = (trig_condition == TA_FALL || trig_condition == TA_LOW) ? !src : src; // R12
		raw = trig_active && ((trig_lvl && !lvl_d_reg) || soft_pulse); // R9 R10 R12
		pass = raw && (div_cnt_reg + 8'h01 >= trig_div_factor); // R15
		fire = (pass && !dly_busy_reg && trig_latency_us == 16'h0000)
			|| (dly_busy_reg && us_tick && dly_cnt_reg == 16'h0000);
	end

	// Divider keeps one of every N qualified events; factor 0 acts as 1.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !trig_active)
		begin
			lvl_d_reg <= trig_lvl; // Tracks the pin, so activation makes no false edge.
			div_cnt_reg <= 8'h00;
		end
		else
		begin
			lvl_d_reg <= trig_lvl;
			if (pass)
				div_cnt_reg <= 8'h00; // R15
			else if (raw)
				div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	// One delay at a time, events during it drop; it fires a tick after zero, never short.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !trig_active)
		begin
			dly_busy_reg <= 1'b0;
			dly_cnt_reg <= 16'h0000;
		end
		else if (pass && !dly_busy_reg && trig_latency_us != 16'h0000)
		begin
			dly_busy_reg <= 1'b1; // R14
			dly_cnt_reg <= trig_latency_us;
		end
		else if (dly_busy_reg && us_tick)
		begin
			dly_cnt_reg <= dly_cnt_reg - 16'h0001; // R14 R23
			dly_busy_reg <= (dly_cnt_reg != 16'h0000);
		end
	end

	// Multiplier: first pulse at once, the rest one per microsecond.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !trig_active)
		begin
			trig_evt <= 1'b0;
			mult_left_reg <= 8'h00;
		end
		else if (fire)
		begin
			trig_evt <= 1'b1;
			mult_left_reg <= (trig_mult_factor == 8'h00) ? 8'h00 : trig_mult_factor - 8'h01; // R16
		end
		else
		begin
			trig_evt <= us_tick && mult_left_reg != 8'h00; // R16
			if (us_tick && mult_left_reg != 8'h00)
				mult_left_reg <= mult_left_reg - 8'h01;
		end
	end
endmodule

// ---- iatc_us_tick.sv ----
`timescale 1ns/1ps
module iatc_us_tick
(
	input wire logic aclk,
	input wire logic aresetn,
	output logic us_tick
);
	import iatc_pkg::*;
	logic [TICK_W-1:0] cnt_reg;

	// One-cycle pulse every microsecond; all delays count these.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg <= '0;
			us_tick <= 1'b0;
		end
		else
		begin
			us_tick <= (cnt_reg == TICK_W'(TICK_CYCLES - 1)); // R23
			cnt_reg <= (cnt_reg == TICK_W'(TICK_CYCLES - 1)) ? '0 : cnt_reg + 1'b1;
		end
	end
endmodule

// ---- test_image_acquisition_trigger_control.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %0h seen %0h", n, e, s); end end
module test_image_acquisition_trigger_control;
	import iatc_pkg::*;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;
		logic [1:0] r;} iatc_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic frame_start, exposure_active, frame_active, line_strobe;
	logic [1:0] s_axi_bresp, s_axi_rresp, knee_slope, rr, sel = 2'h0;
	logic [6:0] knee_saturation_pct, knee_intensity_bound;
	logic [7:0] knee_slope_gradient;
	logic [3:0] trig_line_in;
	int num_errors = 0, compares = 0, nfs = 0, n1, cyc;
	iatc_row_t rows [12] = '{
		'{0, A_MODE, 0, MODE_RST, RESP_OK}, '{0, A_MFC, 0, CNT_RST, RESP_OK},
		'{0, A_EXPO, 0, EXPO_RST, RESP_OK}, '{0, A_TDM, 0, TDM_RST, RESP_OK},
		'{1, A_FRATE, 5, 0, RESP_OK}, '{0, A_FRATE, 0, 0, RESP_OK},
		'{1, A_LRATE, 7, 0, RESP_OK}, '{0, A_LRATE, 0, 0, RESP_OK},
		'{1, A_MODE, 4, 0, RESP_OK}, '{1, A_FRATE, 5, 0, RESP_OK},
		'{0, A_FRATE, 0, 5, RESP_OK}, '{0, 8'h3C, 0, 0, RESP_ERR}};
	iatc_top u_dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_line_in,
		.auto_exposure_us(24'h000002), .frame_start, .exposure_active, .frame_active,
		.line_strobe, .knee_slope, .knee_saturation_pct, .knee_intensity_bound,
		.knee_slope_gradient);
	iatc_line_model u_lines(.aclk, .fire, .sel, .lines(trig_line_in));
	// Free-running clock.
	initial
		forever #10 aclk = ~aclk;
	// Frames are counted on the falling edge so the count never races the waiters.
	always @(negedge aclk)
		if (frame_start === 1'b1)
			nfs++;
	task automatic print_verdict;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tmo;
		num_errors++;
		print_verdict();
	endtask
	// One bus access; the answer lands in q and rr.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
		{s_axi_arvalid, s_axi_rready} <= {2{!w}};
		for (n = 0; n < 99; n++)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if ((s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid))
				break;
		end
		q = s_axi_rdata;
		rr = w ? s_axi_bresp : s_axi_rresp;
		{s_axi_bready, s_axi_rready} <= 2'h0;
		if (n == 99)
			tmo();
	endtask
	task automatic wfs(input int lim);
		int n0;
		n0 = nfs;
		for (cyc = 0; cyc < lim && nfs == n0; cyc++)
			@(posedge aclk);
		if (nfs == n0)
			tmo();
	endtask
	// Polls the acquiring status until it drops.
	task automatic idle;
		for (int k = 0; k < 2000; k++)
		begin
			acc(1'b0, A_STAT, 32'h0);
			if (q[0] === 1'b0)
				return;
		end
		tmo();
	endtask
	task automatic pin(input logic [1:0] s);
		@(posedge aclk);
		{sel, fire} <= {s, 1'b1};
		@(posedge aclk);
		fire <= 1'b0;
	endtask
	// Table first, then the sequencing cases.
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[k])
		begin
			acc(rows[k].w, rows[k].a, rows[k].d);
			`CHK("resp", rows[k].r, rr)
			if (!rows[k].w) `CHK("data", rows[k].e, q)
		end
		$display("table done");
		acc(1'b1, A_EXPO, 32'h2);
		acc(1'b1, A_MODE, 32'h2);
		acc(1'b1, A_MFC, 32'h3);
		nfs = 0;
		acc(1'b1, A_CMD, 32'h1);
		idle();
		`CHK("frames", 3, nfs)
		$display("multi done");
		acc(1'b1, A_MODE, 32'h0);
		acc(1'b1, A_CMD, 32'h1);
		wfs(300);
		n1 = nfs;
		acc(1'b1, A_CMD, 32'h2);
		`CHK("active", 1'b1, frame_active)
		idle();
		`CHK("frames", n1, nfs)
		acc(1'b1, A_CMD, 32'h1);
		wfs(300);
		acc(1'b1, A_CMD, 32'h4);
		repeat (3) @(posedge aclk);
		`CHK("active", 1'b0, frame_active)
		$display("stop abort done");
		acc(1'b1, A_TCFG, 32'h5);
		acc(1'b1, A_TDLY, 32'h2);
		acc(1'b1, A_CMD, 32'h1);
		n1 = nfs;
		repeat (200) @(posedge aclk);
		`CHK("frames", n1, nfs)
		pin(2'h1);
		wfs(300);
		`CHK("delay", 1'b1, cyc >= 100)
		acc(1'b1, A_CMD, 32'h4);
		acc(1'b1, A_TCFG, 32'h1);
		acc(1'b1, A_CMD, 32'h1);
		acc(1'b1, A_CMD, 32'h10);
		wfs(400);
		`CHK("frames", n1 + 2, nfs)
		$display("trigger done");
		print_verdict();
	end
endmodule
